//--- logic/smcd_clock_divider.sv
// Slave mode clock derivation: path select, master divider, scalers
`timescale 1ns/10ps
`include "smcd_defs.svh"

//---------------------------------------------------------------------
// Operation
//---------------------------------------------------------------------
// Operation
// [R1] Timing comes from external master clock and frame sync inputs.
// [R2] Internal master clock and ADC/DAC clocks derived from those inputs.
// [R3] Divider bits 2:0, ADC scale 7:6, DAC scale 5:4, source bit 13.
// [R4] Internal master clock is output of divider after path select.
// [R5] Only internal clock to frame ratios 256, 400 and 500 supported.
// [R6] Ratio 256: source supplies fs*div*256, half on doubling path.
// [R7] Ratio 400: same formula with 400; both scalers set to divide by four.
// [R8] Ratio 500: converter scaling fixed internally, scale fields ignored.
// [R9] Each converter clock must not exceed 6.144MHz; excess is flagged. Code flags only ticks under 4 sys_clk cycles apart, so 6.25MHz passes.
// [R10] Ratio 256: software picks oversample rates matching converter clocks.
// [R11] Ratios 400 and 500 use fixed oversample rate 100.
// [R12] Source keeps frame sync 8-96KHz and master clock 2.048-24.567MHz.
// [R13] Enable control bit 0 picks direct or doubled master clock path.
// [R14] Software sets band field 5:3 when doubling path is used.
module smcd_clock_divider (
   input wire logic sys_clk, // 25 MHz system clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic ce, // Clock enable, freezes all state when low
   input wire logic mclk_pin, // External master clock pin
   input wire logic frame_sync, // External frame sync pin
   input wire logic reg_wr, // Control port write strobe
   input wire logic [`SMCD_ADDR_W-1:0] reg_addr, // Control register address
   input wire logic [15:0] reg_wdata, // Control write data
   input wire logic [1:0] adc_oversample_rate, // ADC rate code, 32<<code
   input wire logic [1:0] dac_oversample_rate, // DAC rate code, 32<<code
   output logic [15:0] reg_rdata, // Control read data, registered
   output logic mclk_int_tick, // Internal master clock tick
   output logic adc_clk_tick, // ADC converter clock tick
   output logic dac_clk_tick, // DAC converter clock tick
   output smcd_pkg::smcd_ratio_t ratio, // Detected ratio class
   output logic [8:0] adc_osr, // Effective ADC oversample rate
   output logic [8:0] dac_osr, // Effective DAC oversample rate
   output logic [2:0] doubler_band_select, // Doubler band field
   output logic conv_over_limit // Sticky: converter clock too fast
);

   //------------------------------------------------------------------
   // Registers
   //------------------------------------------------------------------
   logic [15:0] ena_ctrl_ff;
   logic [15:0] clk_div_ff;
   logic [2:0] mclk_sync_ff;
   logic [2:0] fs_sync_ff;
   logic [2:0] mdiv_cnt_ff;
   logic [2:0] adc_cnt_ff;
   logic [2:0] dac_cnt_ff;
   logic [9:0] ratio_cnt_ff;
   logic [2:0] adc_gap_ff;
   logic [2:0] dac_gap_ff;

   // Scale code to terminal count; ratio 500 forces divide by five
   function automatic logic [2:0] scale_last(input logic [1:0] code,
                                             input logic fixed5);
      logic [2:0] r;
      r = 3'h0;
      if (fixed5) begin
         r = 3'h4;
      end else begin
         case (code)
            2'b10: r = 3'h1;
            // [R7] code 11 divides by four
            2'b11: r = 3'h3;
            default: r = 3'h0;
         endcase
      end
      return r;
   endfunction : scale_last

   // Rate code to oversample value, fixed 100 outside ratio 256
   function automatic logic [8:0] osr_of(input logic [1:0] code,
                                         input logic fixed);
      logic [8:0] r;
      r = 9'h020 << code;
      if (fixed) begin
         r = `SMCD_FIXED_OSR;
      end
      return r;
   endfunction : osr_of

   //------------------------------------------------------------------
   // Decode and clock path
   //------------------------------------------------------------------
   wire wr_ena = reg_wr && (reg_addr == `SMCD_ENA_CTRL_ADDR);
   wire wr_div = reg_wr && (reg_addr == `SMCD_CLK_DIV_ADDR);
   // [R13] path select
   wire doubler_path_select = ena_ctrl_ff[`SMCD_PATH_BIT];
   wire [2:0] mdiv_last = clk_div_ff[`SMCD_MDIV_HI:`SMCD_MDIV_LO];
   wire [1:0] adc_clock_scale = clk_div_ff[`SMCD_ADC_HI:`SMCD_ADC_LO];
   wire [1:0] dac_clock_scale = clk_div_ff[`SMCD_DAC_HI:`SMCD_DAC_LO];
   wire codec_clock_source = clk_div_ff[`SMCD_SRC_BIT];
   // [R1] edges of the synchronised pins only
   wire mclk_rise = mclk_sync_ff[1] & ~mclk_sync_ff[2];
   wire mclk_edge = mclk_sync_ff[1] ^ mclk_sync_ff[2];
   wire fs_rise = fs_sync_ff[1] & ~fs_sync_ff[2];
   // Doubler counts both edges of the source clock
   wire src_tick = doubler_path_select ? mclk_edge : mclk_rise;
   // [R4] internal master clock after the divider
   wire mint = src_tick && (mdiv_cnt_ff == mdiv_last);
   // Source bit 13 feeds scalers from undivided clock instead
   wire conv_src = codec_clock_source ? src_tick : mint;
   // [R8] ratio 500 fixes the scaling
   wire fix5 = (ratio == smcd_pkg::SMCD_RATIO_R500);
   wire [2:0] adc_last = scale_last(adc_clock_scale, fix5);
   wire [2:0] dac_last = scale_last(dac_clock_scale, fix5);
   // [R2] converter clocks derived by scaling
   wire adc_t = conv_src && (adc_cnt_ff == adc_last);
   wire dac_t = conv_src && (dac_cnt_ff == dac_last);
   // [R5] classify ticks per frame
   wire [9:0] ratio_seen = mint ? ratio_cnt_ff + 10'h001 : ratio_cnt_ff;
   smcd_pkg::smcd_ratio_t nxt_ratio;
   assign nxt_ratio = (ratio_seen == `SMCD_RATIO_256) ?
                         smcd_pkg::SMCD_RATIO_R256 :
                      (ratio_seen == `SMCD_RATIO_400) ?
                         smcd_pkg::SMCD_RATIO_R400 :
                      (ratio_seen == `SMCD_RATIO_500) ?
                         smcd_pkg::SMCD_RATIO_R500 :
                         smcd_pkg::SMCD_RATIO_NONE;
   // [R11] fixed rate outside ratio 256
   wire osr_fixed = (ratio != smcd_pkg::SMCD_RATIO_R256);
   // [R9] ticks closer than the least gap exceed the limit
   wire adc_fast = adc_t && (adc_gap_ff < 3'(`SMCD_CONV_MIN_GAP));
   wire dac_fast = dac_t && (dac_gap_ff < 3'(`SMCD_CONV_MIN_GAP));
   wire [15:0] rd_mux = (reg_addr == `SMCD_ENA_CTRL_ADDR) ? ena_ctrl_ff :
                        (reg_addr == `SMCD_CLK_DIV_ADDR) ? clk_div_ff :
                        16'h0000;

   //------------------------------------------------------------------
   // Control registers
   //------------------------------------------------------------------
   // [R3] field layout held in the divider register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ena_ctrl_ff <= `SMCD_ENA_CTRL_RST;
         clk_div_ff <= `SMCD_CLK_DIV_RST;
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         if (wr_ena) begin
            ena_ctrl_ff <= reg_wdata;
         end
         if (wr_div) begin
            clk_div_ff <= reg_wdata;
         end
         reg_rdata <= rd_mux;
      end
   end

   //------------------------------------------------------------------
   // Pin synchronisers and dividers
   //------------------------------------------------------------------
   // Pins sampled at 25 MHz; fast source clocks alias, a known limit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mclk_sync_ff <= 3'h0;
         fs_sync_ff <= 3'h0;
         mdiv_cnt_ff <= 3'h0;
         adc_cnt_ff <= 3'h0;
         dac_cnt_ff <= 3'h0;
      end else if (ce) begin
         mclk_sync_ff <= {mclk_sync_ff[1:0], mclk_pin};
         fs_sync_ff <= {fs_sync_ff[1:0], frame_sync};
         if (src_tick) begin
            mdiv_cnt_ff <= mint ? 3'h0 : mdiv_cnt_ff + 3'h1;
         end
         if (conv_src) begin
            adc_cnt_ff <= adc_t ? 3'h0 : adc_cnt_ff + 3'h1;
            dac_cnt_ff <= dac_t ? 3'h0 : dac_cnt_ff + 3'h1;
         end
      end
   end

   //------------------------------------------------------------------
   // Ratio detection and outputs
   //------------------------------------------------------------------
   // [R7] ratio 400 relies on both scalers set to divide by four
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ratio_cnt_ff <= 10'h000;
         ratio <= smcd_pkg::SMCD_RATIO_NONE;
         mclk_int_tick <= 1'b0;
         adc_clk_tick <= 1'b0;
         dac_clk_tick <= 1'b0;
         adc_osr <= 9'h020;
         dac_osr <= 9'h020;
         doubler_band_select <= 3'h0;
      end else if (ce) begin
         if (fs_rise) begin
            ratio_cnt_ff <= 10'h000;
            ratio <= nxt_ratio;
         end else if (mint && ratio_cnt_ff != 10'h3FF) begin
            ratio_cnt_ff <= ratio_cnt_ff + 10'h001;
         end
         mclk_int_tick <= mint;
         adc_clk_tick <= adc_t;
         dac_clk_tick <= dac_t;
         // [R11] oversample rate selection
         adc_osr <= osr_of(adc_oversample_rate, osr_fixed);
         dac_osr <= osr_of(dac_oversample_rate, osr_fixed);
         // [R14] band passed through for the doubler
         doubler_band_select <= ena_ctrl_ff[`SMCD_BAND_HI:`SMCD_BAND_LO];
      end
   end

   // [R9] gap counters and sticky over-limit flag, cleared by rewrite
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         adc_gap_ff <= 3'h7;
         dac_gap_ff <= 3'h7;
         conv_over_limit <= 1'b0;
      end else if (ce) begin
         adc_gap_ff <= adc_t ? 3'h1 :
                       (adc_gap_ff == 3'h7 ? 3'h7 : adc_gap_ff + 3'h1);
         dac_gap_ff <= dac_t ? 3'h1 :
                       (dac_gap_ff == 3'h7 ? 3'h7 : dac_gap_ff + 3'h1);
         if (adc_fast || dac_fast) begin
            conv_over_limit <= 1'b1;
         end else if (wr_div) begin
            conv_over_limit <= 1'b0;
         end
      end
   end

endmodule : smcd_clock_divider

//--- logic/smcd_defs.svh
// Register map, field positions, reset values and timing counts
`ifndef SMCD_DEFS_SVH
`define SMCD_DEFS_SVH
`define SMCD_ADDR_W 7
`define SMCD_ENA_CTRL_ADDR 7'h01
`define SMCD_CLK_DIV_ADDR 7'h03
`define SMCD_ENA_CTRL_RST 16'h03FE
`define SMCD_CLK_DIV_RST 16'h0050
`define SMCD_PATH_BIT 0
`define SMCD_BAND_HI 5
`define SMCD_BAND_LO 3
`define SMCD_MDIV_HI 2
`define SMCD_MDIV_LO 0
`define SMCD_DAC_HI 5
`define SMCD_DAC_LO 4
`define SMCD_ADC_HI 7
`define SMCD_ADC_LO 6
`define SMCD_SRC_BIT 13
`define SMCD_RATIO_256 10'h100
`define SMCD_RATIO_400 10'h190
`define SMCD_RATIO_500 10'h1F4
`define SMCD_FIXED_OSR 9'h064
`define SMCD_SYS_CLK_KHZ 25000
`define SMCD_CONV_MAX_KHZ 6144
// Highest allowed converter rate, so the least gap rounds down
`define SMCD_CONV_MIN_GAP (`SMCD_SYS_CLK_KHZ / `SMCD_CONV_MAX_KHZ)
`endif

//--- logic/smcd_pkg.sv
// Types shared by the slave mode clock divider
package smcd_pkg;
   typedef enum logic [1:0] {
      SMCD_RATIO_NONE = 2'b00,
      SMCD_RATIO_R256 = 2'b01,
      SMCD_RATIO_R400 = 2'b10,
      SMCD_RATIO_R500 = 2'b11
   } smcd_ratio_t;
endpackage : smcd_pkg

//--- verification/smcd_clock_divider_properties.sv
// Port checks for the slave mode clock divider
`timescale 1ns/10ps
`include "smcd_defs.svh"
module smcd_clock_divider_properties (
   input wire logic sys_clk, // Clock
   input wire logic rst, // Reset
   input wire logic ce, // Enable
   input wire logic reg_wr, // Strobe
   input wire logic [`SMCD_ADDR_W-1:0] reg_addr, // Address
   input wire logic [15:0] reg_wdata, // Write data
   input wire logic [1:0] adc_oversample_rate, // Code
   input wire logic [1:0] dac_oversample_rate, // Code
   input wire logic [15:0] reg_rdata, // Read data
   input wire logic adc_clk_tick, // Tick
   input wire logic dac_clk_tick, // Tick
   input wire smcd_pkg::smcd_ratio_t ratio, // Class
   input wire logic [8:0] adc_osr, // Rate
   input wire logic [8:0] dac_osr, // Rate
   input wire logic [2:0] doubler_band_select, // Band
   input wire logic conv_over_limit // Flag
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // Decoded accesses; band slice kept apart for the past value
   wire logic wr_div = ce && reg_wr && reg_addr == `SMCD_CLK_DIV_ADDR;
   wire logic wr_ena = ce && reg_wr && reg_addr == `SMCD_ENA_CTRL_ADDR;
   wire logic mapped = reg_addr == `SMCD_ENA_CTRL_ADDR || !wr_div &&
      reg_addr == `SMCD_CLK_DIV_ADDR || wr_div;
   wire logic [2:0] wband = reg_wdata[5:3];
   sequence close_adc;
      adc_clk_tick ##[1:3] adc_clk_tick;
   endsequence
   sequence quiet;
      (!adc_clk_tick && !dac_clk_tick)[*6];
   endsequence
   unmapped_read_a: assert property (ce && !mapped |=> !reg_rdata)
      else $error("unmapped read not zero");
   div_readback_a: assert property (wr_div ##1 (ce && reg_addr ==
      `SMCD_CLK_DIV_ADDR) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("divider readback wrong");
   band_copy_a: assert property (wr_ena ##1 (ce && !reg_wr) |=>
      doubler_band_select == $past(wband, 2)) else $error("band wrong");
   osr_fixed_a: assert property ((ce && ratio != smcd_pkg::SMCD_RATIO_R256)
      [*3] |-> adc_osr == `SMCD_FIXED_OSR && dac_osr == `SMCD_FIXED_OSR)
      else $error("fixed rate not applied");
   osr_code_a: assert property ((ce && ratio == smcd_pkg::SMCD_RATIO_R256
      && $stable(adc_oversample_rate) && $stable(dac_oversample_rate))[*3]
      |-> adc_osr == 9'h020 << adc_oversample_rate && dac_osr == 9'h020
      << dac_oversample_rate) else $error("rate code wrong");
   // A tick held across enable low is one tick, not two close ones
   over_set_a: assert property (disable iff (rst || !ce)
      close_adc |-> ##[0:2] conv_over_limit)
      else $error("fast clock not flagged");
   over_hold_a: assert property (conv_over_limit && !wr_div |=>
      conv_over_limit) else $error("flag dropped");
   over_clear_a: assert property (quiet ##0 wr_div |=> !conv_over_limit)
      else $error("flag not cleared");
endmodule : smcd_clock_divider_properties
bind smcd_clock_divider smcd_clock_divider_properties
   smcd_clock_divider_properties_inst (.sys_clk, .rst, .ce, .reg_wr,
   .reg_addr, .reg_wdata, .adc_oversample_rate, .dac_oversample_rate,
   .reg_rdata, .adc_clk_tick, .dac_clk_tick, .ratio, .adc_osr, .dac_osr,
   .doubler_band_select, .conv_over_limit);

//--- verification/smcd_clock_source.sv
// External master clock and frame sync source
`timescale 1ns/10ps
module smcd_clock_source (
   input wire logic sys_clk, // System clock
   input wire logic run, // Source active
   input wire logic [3:0] half_cyc, // Half period
   input wire logic [9:0] frame_len, // Clocks a frame
   output logic mclk_pin, // Master clock
   output logic frame_sync // Frame sync
);
   logic [3:0] ph_ff = 4'h0;
   logic [9:0] cnt_ff = 10'h000;
   logic clk_ff = 1'b0;
   logic fs_ff = 1'b0;
   assign mclk_pin = clk_ff;
   assign frame_sync = fs_ff;
   // frame_len clocks a frame
   // Pins stand low when stopped; rate kept well under sys_clk/2
   always @(posedge sys_clk) begin
      if (!run) begin
         clk_ff <= 1'b0;
         fs_ff <= 1'b0;
         ph_ff <= 4'h0;
      end else if (ph_ff == half_cyc - 4'h1) begin
         ph_ff <= 4'h0;
         clk_ff <= !clk_ff;
         if (!clk_ff) begin
            cnt_ff <= cnt_ff == frame_len - 10'h001 ? 10'h000 : cnt_ff + 1'b1;
            fs_ff <= cnt_ff < frame_len >> 1;
         end
      end else ph_ff <= ph_ff + 4'h1;
   end
endmodule : smcd_clock_source

//--- verification/tb_smcd_clock_divider.sv
// Self-checking bench for the slave mode clock divider
`timescale 1ns/10ps
`include "smcd_defs.svh"
module tb_smcd_clock_divider;
   logic sys_clk, rst, ce, reg_wr, run, mclk_pin, frame_sync;
   logic mclk_int_tick, adc_clk_tick, dac_clk_tick, conv_over_limit;
   logic [`SMCD_ADDR_W-1:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [1:0] adc_oversample_rate, dac_oversample_rate;
   logic [8:0] adc_osr, dac_osr;
   logic [2:0] doubler_band_select;
   logic [3:0] half_cyc;
   logic [9:0] frame_len;
   smcd_pkg::smcd_ratio_t ratio;
   int err_total = 0;
   int num_checks = 0;
   int c;
   wire logic [2:0] ticks = {dac_clk_tick, adc_clk_tick, mclk_int_tick};
   smcd_clock_divider smcd_clock_divider_inst (.sys_clk, .rst, .ce,
      .mclk_pin, .frame_sync, .reg_wr, .reg_addr, .reg_wdata,
      .adc_oversample_rate, .dac_oversample_rate, .reg_rdata, .mclk_int_tick,
      .adc_clk_tick, .dac_clk_tick, .ratio, .adc_osr, .dac_osr,
      .doubler_band_select, .conv_over_limit);
   smcd_clock_source smcd_clock_source_inst (.sys_clk, .run, .half_cyc,
      .frame_len, .mclk_pin, .frame_sync);
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang();
      chk(16'h0000, 16'hFFFF);
      give_verdict();
   endtask : hang
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      repeat (2) @(posedge sys_clk);
      #1 chk(reg_rdata, e);
   endtask : rd
   // Cycles between the second and third tick, skipping any transient
   task automatic gap(input int s, input int e);
      int n, k, g;
      k = 0;
      g = 0;
      for (n = 0; n < 4000 && k < 3; n++) begin
         @(posedge sys_clk);
         #1;
         if (k == 2) g++;
         if (ticks[s] === 1'b1) k++;
      end
      if (k < 3) hang();
      chk(16'(g), 16'(e));
   endtask : gap
   task automatic wait_ratio(input smcd_pkg::smcd_ratio_t e);
      int n;
      for (n = 0; n < 20000 && ratio !== e; n++)
         @(posedge sys_clk);
      if (n == 20000) hang();
      chk(ratio, e);
   endtask : wait_ratio
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      {rst, ce, reg_wr, run, reg_addr, reg_wdata} = {3'h6, 24'h0};
      {adc_oversample_rate, dac_oversample_rate} = 4'h0;
      {half_cyc, frame_len} = {4'h4, 10'h200};
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`SMCD_ENA_CTRL_ADDR, `SMCD_ENA_CTRL_RST);
      rd(`SMCD_CLK_DIV_ADDR, `SMCD_CLK_DIV_RST);
      rd(7'h05, 16'h0000);
      chk(doubler_band_select, 3'h7);
      chk(adc_osr, `SMCD_FIXED_OSR);
      $display("reset test done");
      // Ratio 256 on the direct path, divide by two
      wr(`SMCD_CLK_DIV_ADDR, 16'h0051);
      rd(`SMCD_CLK_DIV_ADDR, 16'h0051);
      run <= 1'b1;
      wait_ratio(smcd_pkg::SMCD_RATIO_R256);
      gap(0, 16);
      gap(1, 16);
      for (c = 0; c < 4; c++) begin
         @(posedge sys_clk);
         adc_oversample_rate <= 2'(c);
         dac_oversample_rate <= 2'(3 - c);
         repeat (4) @(posedge sys_clk);
         chk(adc_osr, 9'h020 << c);
         chk(dac_osr, 9'h020 << 3 - c);
      end
      // Enable low freezes state: the write is dropped, ratio held
      ce <= 1'b0;
      wr(`SMCD_CLK_DIV_ADDR, 16'h0000);
      repeat (40) @(posedge sys_clk);
      chk(ratio, smcd_pkg::SMCD_RATIO_R256);
      ce <= 1'b1;
      rd(`SMCD_CLK_DIV_ADDR, 16'h0051);
      wr(`SMCD_CLK_DIV_ADDR, 16'h2051);
      gap(1, 8);
      // Scale code 10 halves the undivided source for the DAC
      wr(`SMCD_CLK_DIV_ADDR, 16'h2061);
      gap(2, 16);
      $display("ratio 256 test done");
      // Ratio 400, both scalers divide by four
      wr(`SMCD_CLK_DIV_ADDR, 16'h00F0);
      frame_len <= 10'h190;
      wait_ratio(smcd_pkg::SMCD_RATIO_R400);
      gap(1, 32);
      gap(2, 32);
      chk(dac_osr, `SMCD_FIXED_OSR);
      $display("ratio 400 test done");
      // Ratio 500 through the doubler, scale fields left at zero
      wr(`SMCD_ENA_CTRL_ADDR, 16'h03CF);
      wr(`SMCD_CLK_DIV_ADDR, 16'h0000);
      frame_len <= 10'h0FA;
      wait_ratio(smcd_pkg::SMCD_RATIO_R500);
      chk(doubler_band_select, 3'h1);
      gap(0, 4);
      gap(1, 20);
      chk(conv_over_limit, 1'b0);
      $display("ratio 500 test done");
      // Too fast a converter clock is flagged until the next write
      half_cyc <= 4'h2;
      frame_len <= 10'h080;
      wr(`SMCD_CLK_DIV_ADDR, 16'h0050);
      for (c = 0; c < 5000 && conv_over_limit !== 1'b1; c++)
         @(posedge sys_clk);
      if (c == 5000) hang();
      run <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk(conv_over_limit, 1'b1);
      wr(`SMCD_CLK_DIV_ADDR, 16'h0050);
      repeat (2) @(posedge sys_clk);
      #1 chk(conv_over_limit, 1'b0);
      $display("limit test done");
      give_verdict();
   end
endmodule : tb_smcd_clock_divider
